// >>> common/udma_pkg.sv
// Purpose: Shared constants and types for the Ultra DMA burst port
// Assumes: 40 MHz clock; APB register map with byte addresses
// Notes: Burst states are one-hot
package udma_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam logic [7:0] CRC_OFS = 8'h10;
    localparam logic [7:0] CAPS_OFS = 8'h14;
    // Field positions
    localparam int EN_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int IF_LSB = 4;
    localparam int REV_BIT = 6;
    localparam int GO_BIT = 0;
    localparam int WR_BIT = 1;
    localparam int SRST_BIT = 2;
    // Reset values and CRC polynomial
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] CRC_INIT = 16'h4abc;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    typedef enum logic [1:0] {
        IF_MEM = 2'h0,
        IF_IO = 2'h1,
        IF_IDE = 2'h2
    } iface_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_INIT = 5'h02,
        ST_XFER = 5'h04,
        ST_PAUSE = 5'h08,
        ST_TERM = 5'h10
    } burst_e;

    typedef struct packed {
        logic dmack;
        logic stop;
        logic hstrobe;
        logic [15:0] d;
    } pin_in_s;

    typedef struct packed {
        logic dmarq;
        logic dstrobe;
        logic ready;
        logic d_oe_n;
        logic [15:0] d;
    } pin_out_s;

    // Timing in ns
    localparam int CLK_NS = 25;
    localparam int DATA_SETUP_NS = 15;
    localparam int T_CYC_M0_NS = 112;
    localparam int T_CYC_M1_NS = 73;
    localparam int T_CYC_M2_NS = 54;
    localparam int T_CYC_M3_NS = 39;
    localparam int T_CYC_M4_NS = 25;

    function automatic logic [2:0] cyc_up(input int ns);
        return 3'((ns + CLK_NS - 1) / CLK_NS);
    endfunction : cyc_up

    localparam logic [2:0] SETUP_CYC = cyc_up(DATA_SETUP_NS);

    function automatic logic [2:0] half_cyc(input logic [2:0] mode);
        case (mode)
            3'h0: return cyc_up(T_CYC_M0_NS);
            3'h1: return cyc_up(T_CYC_M1_NS);
            3'h2: return cyc_up(T_CYC_M2_NS);
            3'h3: return cyc_up(T_CYC_M3_NS);
            default: return cyc_up(T_CYC_M4_NS);
        endcase
    endfunction : half_cyc
endpackage : udma_pkg

// >>> design/sync2.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes: First stage feeds only the second
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule : sync2

// >>> design/word_crc.sv
// Purpose: Per-burst CRC over 16-bit words
// Assumes: One word per enable pulse
// Notes: Init wins over enable
`timescale 1ns/100ps
module word_crc (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control and data
    input wire logic init,
    input wire logic en,
    input wire logic [15:0] word,
    output logic [15:0] crc
);
    logic [15:0] crc_reg;
    logic [15:0] crc_next;

    function automatic logic [15:0] step(input logic [15:0] c,
                                         input logic [15:0] w);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            fb = r[15] ^ w[i];
            r = {r[14:0], 1'b0} ^ (fb ? udma_pkg::CRC_POLY : 16'h0000);
        end
        return r;
    endfunction : step

    always_comb begin
        crc_next = crc_reg;
        if (init) begin
            crc_next = udma_pkg::CRC_INIT;
        end else if (en) begin
            crc_next = step(crc_reg, word);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            crc_reg <= udma_pkg::CRC_INIT;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;
endmodule : word_crc

// >>> design/udma_port.sv
// Purpose: Device-side Ultra DMA burst engine with APB registers
// Assumes: Pins arrive asynchronously; stream ports share clock
// Notes: Link strobes are sampled, not used as clocks
`timescale 1ns/100ps
module udma_port #(
    parameter int MAX_MODE = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Card pins in burst view
    input wire udma_pkg::pin_in_s pin_i,
    output udma_pkg::pin_out_s pin_o,
    // Word stream to and from the media side
    input wire logic tx_valid,
    input wire logic [15:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [15:0] rx_data,
    input wire logic rx_hold
);
    if (MAX_MODE < 0 || MAX_MODE > 4) begin : g_mode_check
        $error("MAX_MODE must lie in 0..4");
    end

    udma_pkg::pin_in_s pin_s;
    udma_pkg::burst_e state_reg, state_next;
    udma_pkg::iface_e iface_reg;
    udma_pkg::pin_out_s pin_reg, pin_next;
    logic en_reg, rev_reg, cmd_act_reg, dir_wr_reg;
    logic crc_err_reg, done_reg;
    logic [2:0] mode_reg, timer_reg, timer_next;
    logic [15:0] count_reg, rem_reg, rem_next;
    logic [15:0] dout_reg, hcrc_reg, crc_q, rx_data_reg;
    logic req_reg, strobe_reg, strobe_next, loaded_reg, hs_prev_reg;
    logic tx_ready_reg, rx_valid_reg;
    logic [31:0] prdata_reg, rdata;
    logic pready_reg, pslverr_reg;

    sync2 #(.W($bits(udma_pkg::pin_in_s))) u_sync (
        .clock(clock),
        .rst(rst),
        .d(pin_i),
        .q(pin_s)
    );

    // Pin decode
    wire is_io = iface_reg == udma_pkg::IF_IO;
    wire is_ide = iface_reg == udma_pkg::IF_IDE;
    wire req_low = !is_ide;
    wire ack_low = !is_io;
    wire dmack_a = pin_s.dmack ^ ack_low;
    wire stop_a = pin_s.stop;
    wire hrdy_a = !pin_s.hstrobe;
    wire hs_edge = pin_s.hstrobe != hs_prev_reg;
    wire st_idle = state_reg == udma_pkg::ST_IDLE;
    wire st_init = state_reg == udma_pkg::ST_INIT;
    wire st_xfer = state_reg == udma_pkg::ST_XFER;
    wire st_pause = state_reg == udma_pkg::ST_PAUSE;
    wire st_term = state_reg == udma_pkg::ST_TERM;
    wire in_burst = st_xfer || st_pause || st_term;
    wire burst_on = en_reg && cmd_act_reg && req_reg && dmack_a;
    wire rd_burst = !dir_wr_reg && in_burst && dmack_a;
    wire pause_req = dir_wr_reg ? rx_hold : !hrdy_a;
    wire rem_zero = rem_reg == 16'h0000;

    // Burst datapath decode
    wire start = st_idle && en_reg && cmd_act_reg && !rem_zero;
    wire init_ok = dmack_a && (dir_wr_reg || (!stop_a && hrdy_a));
    wire want_word = st_xfer && !dir_wr_reg && !loaded_reg &&
                     !tx_ready_reg && hrdy_a && !stop_a && !rem_zero;
    wire load = tx_ready_reg && tx_valid;
    wire fire = st_xfer && !dir_wr_reg && loaded_reg &&
                timer_reg == 3'h0 && !stop_a;
    wire cap = dir_wr_reg && burst_on && !stop_a && hs_edge &&
               (st_xfer || st_pause);
    wire [15:0] crc_word = dir_wr_reg ? pin_s.d : dout_reg;
    wire burst_end = st_term && !dmack_a;
    wire crc_bad = burst_end && pin_s.d != crc_q;
    wire park = st_term && !dir_wr_reg && stop_a && !strobe_reg;
    wire wr_ready = dir_wr_reg && burst_on && st_xfer && !rx_hold &&
                    !stop_a;

    // APB decode
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pready_reg && pwrite;
    wire hit_ctrl = paddr == udma_pkg::CTRL_OFS;
    wire hit_cmd = paddr == udma_pkg::CMD_OFS;
    wire hit_count = paddr == udma_pkg::COUNT_OFS;
    wire hit_stat = paddr == udma_pkg::STAT_OFS;
    wire hit_crc = paddr == udma_pkg::CRC_OFS;
    wire hit_caps = paddr == udma_pkg::CAPS_OFS;
    wire mapped = hit_ctrl || hit_cmd || hit_count || hit_stat ||
                  hit_crc || hit_caps;
    wire go = wr_acc && hit_cmd && pwdata[udma_pkg::GO_BIT] &&
              !cmd_act_reg && en_reg;
    wire srst = wr_acc && hit_cmd && pwdata[udma_pkg::SRST_BIT];
    wire [2:0] wmode = pwdata[udma_pkg::MODE_LSB +: 3];
    wire mode_ok = int'(wmode) <= MAX_MODE;
    wire [31:0] caps = ~(32'hffffffff << (MAX_MODE + 1));
    wire [31:0] ctrl_w = {25'h0, rev_reg, iface_reg, mode_reg, en_reg};
    wire [31:0] stat_w = {rem_reg, 8'h00, done_reg, crc_err_reg,
                          cmd_act_reg, state_reg};

    assign rdata = hit_ctrl ? ctrl_w :
                   hit_count ? {16'h0000, count_reg} :
                   hit_stat ? stat_w :
                   hit_crc ? {hcrc_reg, crc_q} :
                   hit_caps ? caps : 32'h0000_0000;

    word_crc u_crc (
        .clock(clock),
        .rst(rst),
        .init(start),
        .en(fire || cap),
        .word(crc_word),
        .crc(crc_q)
    );

    // Burst sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            udma_pkg::ST_IDLE: begin
                if (start) state_next = udma_pkg::ST_INIT;
            end
            udma_pkg::ST_INIT: begin
                if (init_ok) state_next = udma_pkg::ST_XFER;
            end
            udma_pkg::ST_XFER: begin
                if (stop_a || rem_zero) begin
                    state_next = udma_pkg::ST_TERM;
                end else if (pause_req) begin
                    state_next = udma_pkg::ST_PAUSE;
                end
            end
            udma_pkg::ST_PAUSE: begin
                if (stop_a) begin
                    state_next = udma_pkg::ST_TERM;
                end else if (!pause_req) begin
                    state_next = udma_pkg::ST_XFER;
                end
            end
            udma_pkg::ST_TERM: begin
                if (!dmack_a) state_next = udma_pkg::ST_IDLE;
            end
            default: state_next = udma_pkg::ST_IDLE;
        endcase
        if (srst) state_next = udma_pkg::ST_IDLE;
    end

    always_comb begin
        timer_next = (timer_reg != 3'h0) ? timer_reg - 3'h1 : 3'h0;
        strobe_next = strobe_reg;
        rem_next = rem_reg;
        if (load && timer_next < udma_pkg::SETUP_CYC) begin
            timer_next = udma_pkg::SETUP_CYC;
        end
        if (fire) begin
            strobe_next = !strobe_reg;
            timer_next = udma_pkg::half_cyc(mode_reg);
            rem_next = rem_reg - 16'h0001;
        end
        if (cap && !rem_zero) rem_next = rem_reg - 16'h0001;
        if (park || start) strobe_next = 1'b1;
        if (go) rem_next = count_reg;
        if (srst) rem_next = 16'h0000;
    end

    // Pins take burst meaning only inside a burst
    assign pin_next = {
        req_reg ^ req_low,
        rd_burst ? strobe_reg : !wr_ready,
        is_ide ? done_reg : (is_io ? !done_reg : !cmd_act_reg),
        !rd_burst,
        dout_reg
    };

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= udma_pkg::ST_IDLE;
            req_reg <= 1'b0;
            strobe_reg <= 1'b1;
            timer_reg <= 3'h0;
            rem_reg <= 16'h0000;
            hs_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg <= state_next == udma_pkg::ST_INIT ||
                       state_next == udma_pkg::ST_XFER ||
                       state_next == udma_pkg::ST_PAUSE;
            strobe_reg <= strobe_next;
            timer_reg <= timer_next;
            rem_reg <= rem_next;
            hs_prev_reg <= pin_s.hstrobe;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loaded_reg <= 1'b0;
            dout_reg <= 16'h0000;
            tx_ready_reg <= 1'b0;
            rx_valid_reg <= 1'b0;
            rx_data_reg <= 16'h0000;
        end else begin
            loaded_reg <= (load || loaded_reg) && !fire && !srst && !start;
            dout_reg <= load ? tx_data : dout_reg;
            tx_ready_reg <= want_word;
            rx_valid_reg <= cap;
            rx_data_reg <= cap ? pin_s.d : rx_data_reg;
        end
    end

    // Registers and command state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_reg <= 1'b0;
            mode_reg <= udma_pkg::MODE_RESET;
            iface_reg <= udma_pkg::IF_MEM;
            rev_reg <= 1'b0;
            count_reg <= udma_pkg::COUNT_RESET;
        end else begin
            if (wr_acc && hit_ctrl && mode_ok) begin
                en_reg <= pwdata[udma_pkg::EN_BIT];
                mode_reg <= wmode;
                iface_reg <= udma_pkg::iface_e'(pwdata[udma_pkg::IF_LSB +: 2]);
                rev_reg <= pwdata[udma_pkg::REV_BIT];
            end else if (srst && rev_reg) begin
                en_reg <= 1'b0;
            end
            if (wr_acc && hit_count) count_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_act_reg <= 1'b0;
            dir_wr_reg <= 1'b0;
            crc_err_reg <= 1'b0;
            done_reg <= 1'b0;
            hcrc_reg <= 16'h0000;
        end else if (srst) begin
            cmd_act_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (go) begin
            cmd_act_reg <= 1'b1;
            dir_wr_reg <= pwdata[udma_pkg::WR_BIT];
            crc_err_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (burst_end) begin
            hcrc_reg <= pin_s.d;
            crc_err_reg <= crc_err_reg || crc_bad;
            cmd_act_reg <= !rem_zero;
            done_reg <= rem_zero;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pin_reg <= {1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            prdata_reg <= setup ? rdata : prdata_reg;
            pin_reg <= pin_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pin_o = pin_reg;
    assign tx_ready = tx_ready_reg;
    assign rx_valid = rx_valid_reg;
    assign rx_data = rx_data_reg;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    burst_gate_a: assert property (
        st_xfer |-> en_reg && cmd_act_reg && req_reg
    ) else $error("Transfer state without burst conditions");
    ack_revert_a: assert property (
        !dmack_a |=> pin_o.d_oe_n
    ) else $error("Data still driven after acknowledge fell");
    write_no_drive_a: assert property (
        dir_wr_reg && $past(dir_wr_reg) |-> pin_o.d_oe_n
    ) else $error("Device drives data in a write burst");
    strobe_word_a: assert property (
        fire && !srst |=> rem_reg == $past(rem_reg) - 16'h0001
    ) else $error("Strobe edge without a word counted");
    data_first_a: assert property (
        load |=> !fire ##1 $stable(dout_reg)
    ) else $error("Strobe edge too soon after new data");
    stop_ack_a: assert property (
        (st_xfer || st_pause) && stop_a && !srst |=> !req_reg
    ) else $error("Request not dropped after stop");
    first_err_a: assert property (
        crc_err_reg && !go |=> crc_err_reg
    ) else $error("Reported CRC error was lost");
    revert_mode_a: assert property (
        srst && !(wr_acc && hit_ctrl) |=> en_reg == ($past(en_reg) &&
                                                     !$past(rev_reg))
    ) else $error("Mode kept or lost wrongly on soft reset");
    pause_take_a: assert property (
        st_pause && cap |=> rx_valid_reg && rx_data_reg == $past(pin_s.d)
    ) else $error("Word lost during pause");
    req_pol_a: assert property (
        ##2 $stable(iface_reg) |-> pin_o.dmarq == ($past(req_reg) ^
                                                   $past(req_low))
    ) else $error("Request polarity wrong for interface mode");

    read_burst_c: cover property (st_term && !dir_wr_reg ##1 st_idle);
    write_burst_c: cover property (cap ##[1:40] burst_end);
    crc_err_c: cover property (burst_end && crc_bad);
    pause_c: cover property (st_pause ##[1:20] st_xfer);
endmodule : udma_port

// >>> test/host_model.sv
// Purpose: Behavioural host side of the card pins for burst traffic
// Assumes: Strobe half period 100 ns, phase unrelated to device clock
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/100ps
module host_model (
    // Card pins, no address, card enable or space strobe among them
    output udma_pkg::pin_in_s pin_i,
    input wire udma_pkg::pin_out_s pin_o,
    // Interface mode
    input wire udma_pkg::iface_e iface
);
    logic ack = 1'b0;
    logic stp = 1'b1;
    logic hs = 1'b1;
    logic [15:0] dd = 16'h0000;
    logic [15:0] got[$];
    int late = 0;
    realtime t_d = 0;
    wire is_ide = iface == udma_pkg::IF_IDE;
    wire req = is_ide ? pin_o.dmarq : !pin_o.dmarq;
    assign pin_i = '{ack == (iface == udma_pkg::IF_IO), stp, hs, dd};

    always @(pin_o.d) t_d = $realtime;

    function automatic logic [15:0] nxt(input logic [15:0] c,
                                        input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^
                ((c[15] ^ w[i]) ? udma_pkg::CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : nxt

    task automatic burst(input logic wr, input logic [15:0] w[$],
                         input logic bad, input logic halt);
        logic [15:0] crc;
        crc = udma_pkg::CRC_INIT;
        got = {};
        late = 0;
        wait (req === 1'b1);
        #37;
        ack = 1'b1;
        stp = 1'b0;
        hs = wr;
        if (wr) begin
            foreach (w[n]) begin
                while (pin_o.dstrobe !== 1'b0) #25;
                dd = w[n];
                crc = nxt(crc, w[n]);
                #50 hs = ~hs;
                #50;
            end
            // Halt: host ends the burst itself by raising stop
            if (!halt) wait (req !== 1'b1);
        end else begin
            while (req === 1'b1) begin
                @(pin_o.dstrobe or req);
                if (req === 1'b1) begin
                    if ($realtime - t_d < 15.0) late++;
                    got.push_back(pin_o.d);
                    crc = nxt(crc, pin_o.d);
                end
            end
        end
        stp = 1'b1;
        hs = 1'b1;
        #100 dd = bad ? ~crc : crc;
        #50 ack = 1'b0;
        #200 dd = ~dd;
    endtask : burst
endmodule : host_model

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the burst port and its registers
// Assumes: Host pins come from host_model; APB master in this module
// Notes: Strobe edges are sampled by the design clock
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, tx_ready, rx_valid;
    logic tx_valid = 1'b1;
    logic rx_hold = 1'b0;
    logic [15:0] tx_data = 16'h1230, rx_data;
    logic [15:0] rxq[$];
    udma_pkg::pin_in_s pin_i;
    udma_pkg::pin_out_s pin_o;
    udma_pkg::iface_e iface = udma_pkg::IF_MEM;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #12.5 clock = ~clock;

    udma_port i_udma_port (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_hold(rx_hold));
    host_model i_host_model (.pin_i(pin_i), .pin_o(pin_o), .iface(iface));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clock) begin
        cycles++;
        if (tx_ready === 1'b1) tx_data <= tx_data + 16'h1;
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (cycles == 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r,
                       output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    task automatic wait_done(output logic [31:0] s);
        repeat (200) begin
            rd(udma_pkg::STAT_OFS, s);
            if (s[7] === 1'b1) break;
        end
    endtask : wait_done

    task automatic t_regs;
        logic [31:0] v;
        logic e;
        rd(udma_pkg::CTRL_OFS, v);
        check(v, 32'h0);
        rd(udma_pkg::CAPS_OFS, v);
        check(v, 32'h1f);
        apb(1'b0, 8'h3c, 32'h0, v, e);
        check(e, 1'b1);
        wr(udma_pkg::CTRL_OFS, 32'h0b);
        rd(udma_pkg::CTRL_OFS, v);
        check(v, 32'h0);
    endtask : t_regs

    task automatic t_read(input udma_pkg::iface_e f);
        logic [31:0] s;
        logic [15:0] base;
        logic [15:0] q[$];
        iface <= f;
        // Mode twice the interface code: modes 0, 2 and 4
        wr(udma_pkg::CTRL_OFS, 32'h1 | (32'(f) << 2) | (32'(f) << 4));
        wr(udma_pkg::COUNT_OFS, 32'h2);
        base = tx_data;
        wr(udma_pkg::CMD_OFS, 32'h1);
        i_host_model.burst(1'b0, q, 1'b0, 1'b0);
        wait_done(s);
        check(s[6], 1'b0);
        check(i_host_model.got.size(), 2);
        check(i_host_model.got[0], base);
        check(i_host_model.got[1], base + 16'h1);
        check(i_host_model.late, 0);
        check(pin_o.dmarq, f != udma_pkg::IF_IDE);
        check(pin_o.ready, f != udma_pkg::IF_IO);
        check({pin_o.d_oe_n, pin_o.dstrobe}, 2'h3);
    endtask : t_read

    task automatic t_write(input logic bad);
        logic [31:0] s;
        logic [15:0] q[$];
        q = {16'ha5c3, 16'h5a3c, 16'h0ff0};
        rxq = {};
        iface <= udma_pkg::IF_IDE;
        wr(udma_pkg::CTRL_OFS, 32'h25);
        wr(udma_pkg::COUNT_OFS, 32'h3);
        wr(udma_pkg::CMD_OFS, 32'h3);
        fork
            i_host_model.burst(1'b1, q, bad, 1'b0);
            begin
                repeat (12) @(posedge clock);
                rx_hold <= 1'b1;
                repeat (20) @(posedge clock);
                rx_hold <= 1'b0;
            end
        join
        wait_done(s);
        check(s[6], bad);
        check(rxq.size(), 3);
        foreach (q[i]) check(rxq[i], q[i]);
    endtask : t_write

    // Host stops the first burst early with a bad CRC; second burst ends
    task automatic t_split;
        logic [31:0] s;
        logic [15:0] q[$];
        q = {16'h1357, 16'h2468};
        rxq = {};
        wr(udma_pkg::CTRL_OFS, 32'h21);
        wr(udma_pkg::COUNT_OFS, 32'h3);
        wr(udma_pkg::CMD_OFS, 32'h3);
        i_host_model.burst(1'b1, q, 1'b1, 1'b1);
        rd(udma_pkg::STAT_OFS, s);
        check(s[7:5], 3'h3);
        q = {16'h9bdf};
        i_host_model.burst(1'b1, q, 1'b0, 1'b0);
        wait_done(s);
        check(s[6], 1'b1);
        check(rxq.size(), 3);
        check({rxq[0], rxq[1]}, 32'h13572468);
        check(rxq[2], 16'h9bdf);
    endtask : t_split

    task automatic t_reset;
        logic [31:0] v;
        wr(udma_pkg::CTRL_OFS, 32'h27);
        wr(udma_pkg::CMD_OFS, 32'h4);
        rd(udma_pkg::CTRL_OFS, v);
        check(v, 32'h27);
        wr(udma_pkg::CTRL_OFS, 32'h67);
        wr(udma_pkg::CMD_OFS, 32'h4);
        rd(udma_pkg::CTRL_OFS, v);
        check(v, 32'h66);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(udma_pkg::CTRL_OFS, v);
        check(v, 32'h0);
    endtask : t_reset

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        for (int f = 0; f < 3; f++) begin
            t_read(udma_pkg::iface_e'(f));
        end
        t_write(1'b0);
        t_write(1'b1);
        t_write(1'b0);
        t_split();
        t_reset();
        end_of_test();
    end
endmodule : tb_top
